// ### hdl/asc_adc_ctrl.sv
`timescale 1ns/100ps
// ****************************************************************
// converter sequencer top
// ****************************************************************
// Operation
// - five selectable analog input channels
// - eight bit successive approximation result
// - reference is supply or reference pin
// - reset clears registers, module off, aborts
// - clock select bits pick divider or rc
// - channel codes 0 to 4 route input
// - writing go with module on starts
// - hardware clears go at conversion end
// - enable bit clear shuts converter down
// - conversion lasts nine and half periods
// - pin config sets analog or digital
// - analog pins read zero in port
// - conversion ignores pin direction setting
// - digital inputs still convert when selected
// - conversion continues in sleep with rc
// - rc bit period about four microseconds
module asc_adc_ctrl
    import asc_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // device state and port pins
    input  wire logic              SLEEP,
    input  wire logic [4:0]        PORT_IN,
    // analog front end
    input  wire logic              COMP,
    output logic                   ANA_PWR,
    output logic [2:0]             ANA_CHAN,
    output logic                   ANA_REF_EXT,
    output logic                   ANA_SAMPLE,
    output logic [7:0]             ANA_DAC,
    output logic                   DONE_FLAG
);

    asc_ctrl_s                  ctrl;
    asc_ctrl_s                  w_ctrl;
    asc_state_e                 state;
    logic [7:0]                 pin_cfg;
    logic [7:0]                 result;
    logic [7:0]                 sar;
    logic [7:0]                 trial;
    logic [7:0]                 res_bit;
    logic [4:0]                 hcnt;
    logic [1:0]                 conv_sel;
    logic                       half_tick;
    logic                       conv_run;
    logic                       conv_end;
    logic                       conv_abort;
    logic                       done_flag;
    logic                       start_req;
    logic [NUM_CHANNELS-1:0]    port_view;
    logic                       aw_held;
    logic                       w_held;
    logic [ADDR_W-1:0]          aw_addr;
    logic [7:0]                 w_data;
    logic                       w_lane;
    logic                       wr_fire;
    logic                       wr_ok;
    logic [9:0]                 wr_idx;
    logic                       ctrl_wr;
    logic                       pincfg_wr;
    logic                       flag_wr;
    logic [31:0]                rd_mux;
    logic [10:0]                cyc_cnt;

    function automatic logic idx_mapped(input logic [9:0] idx);
        return idx == CTRL_IDX || idx == PINCFG_IDX || idx == RESULT_IDX
            || idx == PORT_IDX || idx == FLAG_IDX;
    endfunction

    // ****************************************************************
    // register bus
    // ****************************************************************
    assign wr_fire   = aw_held && w_held && !S_AXI_BVALID;
    assign wr_idx    = aw_addr[ADDR_W-1:2];
    assign wr_ok     = wr_fire && w_lane;
    assign ctrl_wr   = wr_ok && wr_idx == CTRL_IDX;
    assign pincfg_wr = wr_ok && wr_idx == PINCFG_IDX;
    assign flag_wr   = wr_ok && wr_idx == FLAG_IDX;
    assign w_ctrl    = asc_ctrl_s'(w_data);

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 8'h00;
            w_lane        <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held       <= 1'b1;
                aw_addr       <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end else if (!aw_held && !S_AXI_BVALID) begin
                S_AXI_AWREADY <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held       <= 1'b1;
                w_data       <= S_AXI_WDATA[7:0];
                w_lane       <= S_AXI_WSTRB[0];
                S_AXI_WREADY <= 1'b0;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end else if (!w_held && !S_AXI_BVALID) begin
                S_AXI_WREADY <= 1'b1;
            end
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_port
            assign port_view[gi] = pin_cfg[gi] ? 1'b0 : PORT_IN[gi];
        end
    endgenerate

    always_comb begin
        case (S_AXI_ARADDR[ADDR_W-1:2])
            CTRL_IDX:   rd_mux = {24'h000000, ctrl};
            PINCFG_IDX: rd_mux = {24'h000000, pin_cfg};
            RESULT_IDX: rd_mux = {24'h000000, result};
            PORT_IDX:   rd_mux = {27'h0000000, port_view};
            FLAG_IDX:   rd_mux = {31'h00000000, done_flag};
            default:    rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_mux;
            S_AXI_RRESP   <= idx_mapped(S_AXI_ARADDR[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end else if (!S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ****************************************************************
    // control and configuration registers
    // ****************************************************************
    // start only from idle with module on
    assign start_req = ctrl_wr && w_ctrl.go && w_ctrl.en && state == ST_IDLE
                       && !(SLEEP && w_ctrl.clk_sel != CLK_RC);

    // power down or go cleared aborts
    // sleep stops all but the rc clock
    assign conv_abort = state == ST_CONV
                        && (!ctrl.en || (ctrl_wr && (!w_ctrl.go || !w_ctrl.en))
                            || (SLEEP && conv_sel != CLK_RC));

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl    <= asc_ctrl_s'(CTRL_RST);
            pin_cfg <= PINCFG_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl.clk_sel <= w_ctrl.clk_sel;
                ctrl.chan    <= w_ctrl.chan;
                ctrl.en      <= w_ctrl.en;
            end
            ctrl.rsv <= 1'b0;
            if (start_req) begin
                ctrl.go <= 1'b1;
            end else if (conv_abort || conv_end) begin
                ctrl.go <= 1'b0;
            end
            if (pincfg_wr) begin
                pin_cfg <= w_data;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            done_flag <= 1'b0;
        end else if (conv_end) begin
            done_flag <= 1'b1;
        end else if (flag_wr && w_data[0]) begin
            done_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // successive approximation sequencer
    // ****************************************************************
    assign conv_run = state == ST_CONV;

    asc_tad_div u_div (
        .clk  (CLK),
        .rst  (RST),
        .run  (conv_run),
        .sel  (conv_sel),
        .tick (half_tick)
    );

    // keep trial bit when input above it
    assign res_bit = COMP ? sar : (sar & ~trial);

    // clock select is latched at start; changing it mid conversion
    // would corrupt the bit timing
    always_ff @(posedge CLK) begin
        if (RST) begin
            state    <= ST_IDLE;
            hcnt     <= 5'h00;
            sar      <= 8'h00;
            trial    <= 8'h00;
            conv_sel <= CLK_DIV2;
            result   <= RESULT_RST;
            conv_end <= 1'b0;
        end else begin
            conv_end <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state    <= ST_CONV;
                        hcnt     <= 5'h00;
                        sar      <= 8'h00;
                        trial    <= TRIAL_MSB;
                        conv_sel <= w_ctrl.clk_sel;
                    end
                end
                ST_CONV: begin
                    if (conv_abort) begin
                        state <= ST_IDLE;
                        sar   <= 8'h00;
                        trial <= 8'h00;
                    end else if (half_tick) begin
                        hcnt <= hcnt + 5'h01;
                        if (hcnt == SETUP_HALVES - 5'h01) begin
                            sar <= trial;
                        end else if (hcnt >= SETUP_HALVES && !hcnt[0]) begin
                            sar   <= res_bit | (trial >> 1);
                            trial <= trial >> 1;
                            if (hcnt == CONV_HALVES - 5'h01) begin
                                result   <= res_bit;
                                conv_end <= 1'b1;
                                state    <= ST_IDLE;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // analog front end drive
    // ****************************************************************
    // mux ignores pin direction
    assign ANA_CHAN    = ctrl.chan;
    assign ANA_PWR     = ctrl.en;
    assign ANA_DAC     = sar;
    assign DONE_FLAG   = done_flag;
    assign ANA_REF_EXT = pin_cfg[REF_EXT_BIT];

    // hold stage tracks while enabled and idle, and through the first two of the three setup halves
    always_ff @(posedge CLK) begin
        if (RST) begin
            ANA_SAMPLE <= 1'b0;
        end else begin
            ANA_SAMPLE <= ctrl.en && (state == ST_IDLE || hcnt < SETUP_HALVES - 5'h01);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RST || state != ST_CONV) begin
            cyc_cnt <= 11'h000;
        end else begin
            cyc_cnt <= cyc_cnt + 11'h001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_last_tick;
        state == ST_CONV && half_tick && hcnt == CONV_HALVES - 5'h01 && !conv_abort;
    endsequence
    sequence s_store_then_clear;
        (conv_end && ctrl.go && result == $past(res_bit)) ##1 (!ctrl.go || $past(start_req));
    endsequence

    reset_clear_a: assert property (disable iff (1'b0) RST |=>
        (ctrl == asc_ctrl_s'(CTRL_RST) && pin_cfg == PINCFG_RST && state == ST_IDLE))
        else $error("registers not cleared by reset");
    go_start_a: assert property (start_req |=> ctrl.go && state == ST_CONV)
        else $error("start write did not begin conversion");
    go_clear_a: assert property (conv_end && !start_req |=> !ctrl.go)
        else $error("go not cleared at conversion end");
    result_order_a: assert property (s_last_tick |=> s_store_then_clear)
        else $error("result not stored before go cleared");
    conv_len_a: assert property (conv_end |->
        cyc_cnt == 11'(CONV_HALVES) * 11'(asc_half_len(conv_sel)) + 11'h001)
        else $error("conversion length wrong");
    off_abort_a: assert property (state == ST_CONV && !ctrl.en |=>
        state == ST_IDLE && !ctrl.go)
        else $error("disabled module kept converting");
    sleep_rc_a: assert property (state == ST_CONV && SLEEP && conv_sel == CLK_RC
        && ctrl.en && !ctrl_wr |=> state == ST_CONV || conv_end)
        else $error("rc clocked conversion stopped in sleep");
    chan_route_a: assert property (ctrl_wr |=> ANA_CHAN == $past(w_ctrl.chan))
        else $error("channel select not routed");
    port_mask_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        && S_AXI_ARADDR[ADDR_W-1:2] == PORT_IDX |=>
        (S_AXI_RDATA[4:0] & $past(pin_cfg[4:0])) == 5'h00)
        else $error("analog pin read nonzero");
    done_set_a: assert property (conv_end |=> DONE_FLAG)
        else $error("done flag not set");
    ref_sel_a: assert property (pincfg_wr |=> ANA_REF_EXT == $past(w_data[REF_EXT_BIT]))
        else $error("reference select not applied");

endmodule

// ### inc/asc_pkg.sv
// ****************************************************************
// shared constants and types for the converter sequencer
// ****************************************************************
package asc_pkg;

    localparam int          ADDR_W        = 12;
    localparam int          NUM_CHANNELS  = 5;

    // register indices; byte address is four times the index
    localparam logic [9:0]  CTRL_IDX      = 10'h01f;
    localparam logic [9:0]  PINCFG_IDX    = 10'h09f;
    localparam logic [9:0]  RESULT_IDX    = 10'h01e;
    localparam logic [9:0]  PORT_IDX      = 10'h005;
    localparam logic [9:0]  FLAG_IDX      = 10'h020;

    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  PINCFG_RST    = 8'h00;
    localparam logic [7:0]  RESULT_RST    = 8'h00;
    localparam int          REF_EXT_BIT   = 5;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // conversion clock select codes
    localparam logic [1:0]  CLK_DIV2      = 2'h0;
    localparam logic [1:0]  CLK_DIV8      = 2'h1;
    localparam logic [1:0]  CLK_DIV32     = 2'h2;
    localparam logic [1:0]  CLK_RC        = 2'h3;

    // half bit period lengths in system clock cycles
    localparam int          CLK_PERIOD_NS      = 25;
    localparam int          RC_BIT_PERIOD_NS   = 4000;
    localparam logic [6:0]  HALF_DIV2          = 7'h01;
    localparam logic [6:0]  HALF_DIV8          = 7'h04;
    localparam logic [6:0]  HALF_DIV32         = 7'h10;
    localparam logic [6:0]  HALF_RC            = 7'(RC_BIT_PERIOD_NS / (2 * CLK_PERIOD_NS));

    // a conversion is 19 half bit periods: 3 of setup, then 2 per result bit
    localparam logic [4:0]  CONV_HALVES   = 5'h13;
    localparam logic [4:0]  SETUP_HALVES  = 5'h03;
    localparam logic [7:0]  TRIAL_MSB     = 8'h80;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic       go;
        logic       rsv;
        logic       en;
    } asc_ctrl_s;

    typedef enum logic {ST_IDLE, ST_CONV} asc_state_e;

    function automatic logic [6:0] asc_half_len(input logic [1:0] sel);
        case (sel)
            CLK_DIV2:  return HALF_DIV2;
            CLK_DIV8:  return HALF_DIV8;
            CLK_DIV32: return HALF_DIV32;
            default:   return HALF_RC;
        endcase
    endfunction

endpackage

// ### hdl/asc_tad_div.sv
`timescale 1ns/100ps
// ****************************************************************
// half bit period tick generator
// ****************************************************************
module asc_tad_div
    import asc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [1:0] sel,
    // tick out
    output logic            tick
);

    logic [6:0] cnt;
    logic [6:0] lim;

    assign lim = asc_half_len(sel);

    // counter restarts whenever the converter is idle so every
    // conversion starts on a full half period
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt  <= 7'h00;
            tick <= 1'b0;
        end else if (cnt == lim - 7'h01) begin
            cnt  <= 7'h00;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 7'h01;
            tick <= 1'b0;
        end
    end

endmodule

// ### tb/asc_afe_model.sv
`timescale 1ns/100ps
// ****************************************************************
// comparator and input pins on the far side of the sequencer
// ****************************************************************
module asc_afe_model
    import asc_pkg::*;
(
    // converter controls
    input  wire logic            pwr,
    input  wire logic [2:0]      chan,
    input  wire logic [7:0]      dac,
    // pin levels as codes
    input  wire logic [4:0][7:0] lvl,
    // comparator out
    output logic                 comp
);
    // five pins, level only
    // pin direction is not modelled: the selected level is converted as it stands
    always_comb begin
        if (!pwr || chan >= 3'(NUM_CHANNELS)) begin
            comp = 1'b0;
        end else begin
            comp = (lvl[chan] >= dac);
        end
    end
endmodule

// ### tb/test_adc_sequencer_control.sv
`timescale 1ns/100ps
// ****************************************************************
// self-checking bench
// ****************************************************************
module test_adc_sequencer_control;
    import asc_pkg::*;
    localparam logic [11:0] A_CTRL = {CTRL_IDX, 2'b00};
    localparam logic [11:0] A_PCFG = {PINCFG_IDX, 2'b00};
    localparam logic [11:0] A_RES  = {RESULT_IDX, 2'b00};
    localparam logic [11:0] A_PORT = {PORT_IDX, 2'b00};
    localparam logic [11:0] A_FLAG = {FLAG_IDX, 2'b00};
    localparam int          LIMIT  = 30000;
    logic clk = 1'b0, rst = 1'b1, sleep = 1'b0, comp, pwr, ref_ext, done;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sample;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic [2:0]  chan;
    logic [7:0]  dac;
    logic [4:0]  port_in = 5'h00;
    logic [4:0][7:0] lvl = '0;
    int cyc = 0, miscompares = 0, num_checks = 0;

    always #12.5 clk = ~clk;

    asc_adc_ctrl u_asc_adc_ctrl (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .SLEEP(sleep), .PORT_IN(port_in), .COMP(comp),
        .ANA_PWR(pwr), .ANA_CHAN(chan), .ANA_REF_EXT(ref_ext), .ANA_SAMPLE(sample),
        .ANA_DAC(dac), .DONE_FLAG(done));

    asc_afe_model u_asc_afe_model (.pwr(pwr), .chan(chan), .dac(dac), .lvl(lvl),
        .comp(comp));

    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hang shows up as a mismatch and still reaches the report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // ****************************************************************
    // bus cycles
    // ****************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_vals();
        logic [31:0] d;
        logic [1:0] r;
        rd(A_CTRL, d, r); chk(d, {24'h0, CTRL_RST});
        rd(A_PCFG, d, r); chk(d, {24'h0, PINCFG_RST});
        rd(A_RES, d, r);  chk(d, {24'h0, RESULT_RST});
        chk(pwr, 1'b0);
    endtask

    // one whole conversion, timed from the end of the starting write
    task automatic conv(input logic [1:0] s, input logic [2:0] c, input logic [7:0] v);
        logic [31:0] d;
        logic [1:0] r;
        int t0, h, n;
        h = (s == CLK_DIV2) ? 1 : (s == CLK_DIV8) ? 4 : (s == CLK_DIV32) ? 16 : 80;
        lvl[c] <= v;
        wr(A_CTRL, {24'h0, s, c, 3'b101}, r);
        t0 = cyc;
        chk(chan, c);
        chk(pwr, 1'b1);
        rd(A_CTRL, d, r); chk(d[2], 1'b1);
        while (!done) @(posedge clk);
        n = cyc - t0;
        chk(n >= 19 * h - 2 && n <= 19 * h + 3, 1'b1);
        rd(A_RES, d, r);  chk(d, {24'h0, v});
        rd(A_CTRL, d, r); chk(d, {24'h0, s, c, 3'b001});
        wr(A_FLAG, 32'h1, r);
        rd(A_FLAG, d, r); chk(d, 32'h0);
    endtask

    task automatic t_abort();
        logic [31:0] d;
        logic [1:0] r;
        wr(A_CTRL, {24'h0, CLK_DIV32, 3'h1, 3'b101}, r);
        repeat (40) @(posedge clk);
        wr(A_CTRL, 32'h0, r);
        chk(pwr, 1'b0);
        repeat (320) @(posedge clk);
        chk(done, 1'b0);
        wr(A_CTRL, {24'h0, CLK_RC, 3'h2, 3'b101}, r);
        repeat (100) @(posedge clk);
        do_reset();
        rd(A_CTRL, d, r); chk(d, 32'h0);
        repeat (1600) @(posedge clk);
        chk(done, 1'b0);
    endtask

    task automatic t_pins();
        logic [31:0] d;
        logic [1:0] r;
        wr(A_PCFG, 32'h35, r);
        rd(A_PCFG, d, r); chk(d, 32'h35);
        chk(ref_ext, 1'b1);
        port_in <= 5'h1f;
        rd(A_PORT, d, r); chk(d, 32'h0a);
        wr(A_PCFG, 32'h0, r);
        rd(A_PORT, d, r); chk(d, 32'h1f);
    endtask

    task automatic t_map();
        logic [31:0] d;
        logic [1:0] r;
        wr(A_CTRL, 32'hc3, r);
        rd(A_CTRL, d, r); chk(d, 32'hc1);
        wr(12'h100, 32'hff, r); chk(r, RESP_SLVERR);
        rd(12'h100, d, r); chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        wr(A_CTRL, 32'h0, r);
    endtask

    initial begin
        logic [7:0] tbl [5];
        tbl = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01};
        do_reset();
        t_reset_vals();
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            conv(CLK_RC, 3'(i), tbl[i]);
        end
        conv(CLK_DIV2, 3'h1, 8'h3c);
        conv(CLK_DIV8, 3'h2, 8'h7f);
        conv(CLK_DIV32, 3'h3, 8'h80);
        sleep <= 1'b1;
        conv(CLK_RC, 3'h4, 8'hc3);
        sleep <= 1'b0;
        t_abort();
        t_pins();
        t_map();
        tally_and_finish();
    end
endmodule
